// file: hdl/eau_unit.sv
`timescale 1ns/1ps
`include "eau_map.svh"
// Notes on behaviour
// - word data access clears address bit zero
// - instruction fetch aligned like word data
// - condition byte pushed doubled, popped from top
// - register direct picks byte or word register
// - word registers only for listed word operations
// - register indirect uses full register content
// - displacement adds bytes three/four to the register, moves only
// - post increment: use, then add one/two
// - pre decrement: subtract one/two, then use
// - short absolute forces upper byte all ones
// - absolute forms limited to listed operations
// - immediates from byte two or three/four
// - small constant ops imply one or two
// - bit number from byte two or four
// - branch offset sign extended, added to next pc
// - memory indirect reads vector in page zero
// - odd branch or word move target made even
// - alu uses registers, some byte immediates
// - transfers refuse pc relative and indirect
// - bit ops use direct, indirect, short absolute
// - program counter bit zero always zero
// - register seven serves as stack pointer
module eau_unit (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // decoder request
    input  wire logic              req_valid,
    input  wire eau_pkg::eau_req_t req,
    // general register file read
    output logic [2:0]             gr_rd_sel,
    input  wire logic [15:0]       gr_rd_data,
    // memory read for indirect vector
    output logic                   vec_rd,
    output logic [15:0]            vec_addr,
    input  wire logic              vec_ack,
    input  wire logic [15:0]       vec_data,
    // result
    output logic                   res_valid,
    output eau_pkg::eau_res_t      res,
    output logic [15:0]            ccr_word,
    output logic [7:0]             ccr_popped
);
    import eau_pkg::*;

    // ****************************************
    // helper functions
    // ****************************************
    // clear bit zero of an address
    function automatic logic [15:0] even_addr(input logic [15:0] a);
        even_addr = a & `EAU_EVEN_MASK;
    endfunction

    // step for byte or word moves
    function automatic logic [15:0] step(input logic w);
        step = w ? `EAU_STEP_WORD : `EAU_STEP_BYTE;
    endfunction

    // ****************************************
    // request decode
    // ****************************************
    eau_state_t  state;               // control state
    eau_state_t  next_state;          // next control state
    eau_req_t    held;                // captured request
    logic [15:0] gr_val;              // register read result
    logic        is_word;             // word sized access
    logic        legal;               // mode permitted for op
    logic [15:0] rd_byte;             // byte register operand
    logic [15:0] sext_disp;           // sign extended branch offset
    logic [15:0] step_val;            // increment size
    logic [15:0] raw_addr;            // address before alignment
    logic        mem_use;             // mode touches memory
    logic        moves;               // any move instruction
    logic        sp_sel;              // stack pointer selected
    eau_res_t    next_res;            // result being formed

    assign gr_val = gr_rd_data;
    assign moves  = (held.op == EAU_OP_BYTE_MOVE) ||
                    (held.op == EAU_OP_WORD_MOVE);
    assign sp_sel = (held.reg_sel == `EAU_SP_INDEX);

    // word sized classes; all others work on bytes
    assign is_word = (held.op == EAU_OP_WORD_MOVE)   ||
                     (held.op == EAU_OP_WORD_ARITH)  ||
                     (held.op == EAU_OP_SMALL_CONST) ||
                     (held.op == EAU_OP_MUL_DIV)     ||
                     (held.op == EAU_OP_STACK)       ||
                     (held.op == EAU_OP_JUMP)        ||
                     (held.op == EAU_OP_BRANCH)      ||
                     (held.op == EAU_OP_FETCH);

    // byte register: high or low half of the pair
    assign rd_byte = {8'h00, held.reg_high ? gr_val[15:8]
                                           : gr_val[7:0]};

    assign sext_disp = {{8{held.byte2[7]}}, held.byte2};
    assign step_val  = step(held.op == EAU_OP_WORD_MOVE);

    // mode legality per instruction class
    always_comb begin
        case (held.mode)
            EAU_M_REG_DIRECT: legal = (held.op != EAU_OP_JUMP) &&
                                      (held.op != EAU_OP_BRANCH);
            EAU_M_REG_IND:    legal = moves ||
                                      (held.op == EAU_OP_BIT) ||
                                      (held.op == EAU_OP_BIT_REGNUM) ||
                                      (held.op == EAU_OP_JUMP);
            EAU_M_DISP:       legal = moves;
            // byte post/pre on the stack pointer is refused
            EAU_M_POST_INC,
            EAU_M_PRE_DEC:    legal = moves && !(sp_sel &&
                                      held.op == EAU_OP_BYTE_MOVE);
            EAU_M_ABS_SHORT:  legal = (held.op == EAU_OP_BYTE_MOVE) ||
                                      (held.op == EAU_OP_BIT) ||
                                      (held.op == EAU_OP_BIT_REGNUM);
            EAU_M_ABS_LONG:   legal = moves ||
                                      (held.op == EAU_OP_JUMP);
            EAU_M_IMM8:       legal = (held.op == EAU_OP_BYTE_MOVE) ||
                                      (held.op == EAU_OP_ALU_IMM) ||
                                      (held.op == EAU_OP_SMALL_CONST) ||
                                      (held.op == EAU_OP_BIT);
            EAU_M_IMM16:      legal = (held.op == EAU_OP_WORD_MOVE);
            EAU_M_PC_REL:     legal = (held.op == EAU_OP_BRANCH);
            EAU_M_MEM_IND:    legal = (held.op == EAU_OP_JUMP);
            EAU_M_CCR_PUSH,
            EAU_M_CCR_POP:    legal = (held.op == EAU_OP_STACK);
            EAU_M_FETCH:      legal = (held.op == EAU_OP_FETCH);
            default:          legal = 1'b0;
        endcase
    end

    // address source per mode
    always_comb begin
        raw_addr = `EAU_RST_ADDR;
        mem_use  = 1'b1;
        case (held.mode)
            EAU_M_REG_IND:   raw_addr = gr_val;
            EAU_M_DISP:      raw_addr = gr_val + held.word34;
            EAU_M_POST_INC:  raw_addr = gr_val;
            EAU_M_PRE_DEC:   raw_addr = gr_val - step_val;
            EAU_M_ABS_SHORT: raw_addr = {`EAU_SHORT_PAGE,
                                         held.byte2};
            EAU_M_ABS_LONG:  raw_addr = held.word34;
            EAU_M_PC_REL:    raw_addr = held.pc_next + sext_disp;
            EAU_M_MEM_IND:   raw_addr = vec_data;
            EAU_M_CCR_PUSH:  raw_addr = gr_val - `EAU_STEP_WORD;
            EAU_M_CCR_POP:   raw_addr = gr_val;
            EAU_M_FETCH:     raw_addr = held.pc_next;
            default: begin
                raw_addr = `EAU_RST_ADDR;
                mem_use  = 1'b0;
            end
        endcase
    end

    // assemble the result
    always_comb begin
        next_res            = '0;
        next_res.mem_access = mem_use && legal;
        next_res.word       = is_word;
        next_res.illegal    = !legal;
        next_res.is_write   = (held.mode == EAU_M_PRE_DEC) ||
                              (held.mode == EAU_M_CCR_PUSH);
        // word access, fetch and branch targets aligned
        next_res.addr       = is_word ? even_addr(raw_addr)
                                      : raw_addr;
        next_res.bitnum     = held.bitnum_in_b4 ? held.bitnum4
                                                : held.byte2[2:0];
        case (held.mode)
            EAU_M_REG_DIRECT: next_res.operand = is_word ? gr_val
                                                         : rd_byte;
            EAU_M_IMM8:       next_res.operand =
                                  (held.op == EAU_OP_SMALL_CONST) ?
                                  step(held.small_two) :
                                  {8'h00, held.byte2};
            EAU_M_IMM16:      next_res.operand = held.word34;
            EAU_M_CCR_PUSH:   next_res.operand = {held.condition_code_byte,
                                                  held.condition_code_byte};
            default:          next_res.operand = `EAU_RST_WORD;
        endcase
        // register write back for stepping modes
        next_res.wb_sel = held.reg_sel;
        case (held.mode)
            EAU_M_POST_INC: begin
                next_res.wb_en  = legal;
                next_res.wb_val = gr_val + step_val;
            end
            EAU_M_PRE_DEC: begin
                next_res.wb_en  = legal;
                next_res.wb_val = gr_val - step_val;
            end
            EAU_M_CCR_PUSH: begin
                next_res.wb_en  = 1'b1;
                next_res.wb_sel = `EAU_SP_INDEX;
                next_res.wb_val = gr_val - `EAU_STEP_WORD;
            end
            EAU_M_CCR_POP: begin
                next_res.wb_en  = 1'b1;
                next_res.wb_sel = `EAU_SP_INDEX;
                next_res.wb_val = gr_val + `EAU_STEP_WORD;
            end
            default: begin
                next_res.wb_en  = 1'b0;
                next_res.wb_val = `EAU_RST_WORD;
            end
        endcase
    end

    // ****************************************
    // control state machine
    // ****************************************
    // stack modes read the stack pointer, others the named register
    logic [2:0] next_rd_sel;
    assign next_rd_sel = ((req.mode == EAU_M_CCR_PUSH) ||
                          (req.mode == EAU_M_CCR_POP)) ?
                         `EAU_SP_INDEX : req.reg_sel;

    logic need_vec;                    // indirect vector read pending
    assign need_vec = (held.mode == EAU_M_MEM_IND) && legal;

    // a pop must wait for the stack word, or junk lands in the byte
    logic need_pop;                    // stack word pop pending
    assign need_pop = (held.mode == EAU_M_CCR_POP) && legal;

    always_comb begin
        case (state)
            EAU_S_IDLE: next_state = req_valid ? EAU_S_WAIT : EAU_S_IDLE;
            EAU_S_WAIT: next_state = (!(need_vec || need_pop) || vec_ack) ?
                                     EAU_S_DONE : EAU_S_WAIT;
            EAU_S_DONE: next_state = EAU_S_IDLE;
            default:    next_state = EAU_S_IDLE;
        endcase
    end

    // state and request capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= EAU_S_IDLE;
            held      <= '0;
            gr_rd_sel <= `EAU_RST_REG;
        end else begin
            state <= next_state;
            if (state == EAU_S_IDLE && req_valid) begin
                held      <= req;
                gr_rd_sel <= next_rd_sel;
            end
        end
    end

    // vector read in page zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_rd   <= 1'b0;
            vec_addr <= `EAU_RST_ADDR;
        end else begin
            vec_rd   <= (next_state == EAU_S_WAIT) &&
                        (state == EAU_S_WAIT) && need_vec && !vec_ack;
            vec_addr <= {`EAU_IND_PAGE, held.byte2};
        end
    end

    // result registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            res_valid  <= 1'b0;
            res        <= '0;
            ccr_word   <= `EAU_RST_WORD;
            ccr_popped <= `EAU_RST_BYTE;
        end else begin
            res_valid <= (next_state == EAU_S_DONE);
            if (next_state == EAU_S_DONE) begin
                res <= next_res;
                // doubled byte for stack writes
                ccr_word   <= {held.condition_code_byte, held.condition_code_byte};
                // upper half kept, lower half dropped
                ccr_popped <= vec_data[15:8];
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_word_even;
        @(posedge clk) disable iff (!rst_b)
        res_valid && res.word |-> res.addr[0] == 1'b0;
    endproperty
    a_word_even: assert property (p_word_even)
        else $error("word address odd");

    property p_short_page;
        @(posedge clk) disable iff (!rst_b)
        res_valid && held.mode == EAU_M_ABS_SHORT |->
            res.addr[15:8] == 8'hFF;
    endproperty
    a_short_page: assert property (p_short_page)
        else $error("short absolute page wrong");

    property p_post_inc;
        @(posedge clk) disable iff (!rst_b)
        res_valid && held.mode == EAU_M_POST_INC && !res.illegal |->
            res.wb_val == gr_val + step(res.word) &&
            res.addr == (res.word ? even_addr(gr_val) : gr_val);
    endproperty
    a_post_inc: assert property (p_post_inc)
        else $error("post increment step wrong");

    property p_pre_dec;
        @(posedge clk) disable iff (!rst_b)
        res_valid && held.mode == EAU_M_PRE_DEC && !res.illegal |->
            res.addr == (res.word ? even_addr(res.wb_val) : res.wb_val);
    endproperty
    a_pre_dec: assert property (p_pre_dec)
        else $error("pre decrement address wrong");

    property p_ccr_push;
        @(posedge clk) disable iff (!rst_b)
        res_valid |-> ccr_word[15:8] == ccr_word[7:0];
    endproperty
    a_ccr_push: assert property (p_ccr_push)
        else $error("condition word halves differ");

    property p_no_rel_move;
        @(posedge clk) disable iff (!rst_b)
        res_valid && moves && (held.mode == EAU_M_PC_REL ||
            held.mode == EAU_M_MEM_IND) |-> res.illegal;
    endproperty
    a_no_rel_move: assert property (p_no_rel_move)
        else $error("transfer took pc relative");

    property p_done_bound;
        @(posedge clk) disable iff (!rst_b)
        state == EAU_S_IDLE && req_valid && req.mode != EAU_M_MEM_IND &&
            req.mode != EAU_M_CCR_POP |-> ##2 res_valid;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("result late");

    property p_vec_page;
        @(posedge clk) disable iff (!rst_b)
        vec_rd |-> vec_addr[15:8] == 8'h00;
    endproperty
    a_vec_page: assert property (p_vec_page)
        else $error("vector outside page zero");

    c_indirect: cover property (@(posedge clk)
        res_valid && held.mode == EAU_M_MEM_IND);
    c_branch: cover property (@(posedge clk)
        res_valid && held.mode == EAU_M_PC_REL && !res.illegal);
    c_push: cover property (@(posedge clk)
        res_valid && held.mode == EAU_M_CCR_PUSH);
endmodule // eau_unit

// file: hdl/eau_map.svh
`ifndef EAU_MAP_SVH
`define EAU_MAP_SVH
// short absolute page (upper byte all ones)
`define EAU_SHORT_PAGE      8'hFF
// memory indirect page (upper byte zero)
`define EAU_IND_PAGE        8'h00
// step sizes for post-increment and pre-decrement
`define EAU_STEP_BYTE       16'h0001
`define EAU_STEP_WORD       16'h0002
// index of the stack pointer register
`define EAU_SP_INDEX        3'h7
// word alignment mask: bit 0 cleared
`define EAU_EVEN_MASK       16'hFFFE
// reset values
`define EAU_RST_ADDR        16'h0000
`define EAU_RST_WORD        16'h0000
`define EAU_RST_BYTE        8'h00
`define EAU_RST_BITNUM      3'h0
`define EAU_RST_REG         3'h0
`endif

// file: hdl/eau_pkg.sv
package eau_pkg;
    // addressing modes
    typedef enum logic [3:0] {
        EAU_M_REG_DIRECT = 4'h0,
        EAU_M_REG_IND    = 4'h1,
        EAU_M_DISP       = 4'h2,
        EAU_M_POST_INC   = 4'h3,
        EAU_M_PRE_DEC    = 4'h4,
        EAU_M_ABS_SHORT  = 4'h5,
        EAU_M_ABS_LONG   = 4'h6,
        EAU_M_IMM8       = 4'h7,
        EAU_M_IMM16      = 4'h8,
        EAU_M_PC_REL     = 4'h9,
        EAU_M_MEM_IND    = 4'hA,
        EAU_M_CCR_PUSH   = 4'hB,
        EAU_M_CCR_POP    = 4'hC,
        EAU_M_FETCH      = 4'hD
    } eau_mode_t;

    // instruction classes that may use the unit
    typedef enum logic [3:0] {
        EAU_OP_BYTE_MOVE   = 4'h0,
        EAU_OP_WORD_MOVE   = 4'h1,
        EAU_OP_WORD_ARITH  = 4'h2,
        EAU_OP_SMALL_CONST = 4'h3,
        EAU_OP_MUL_DIV     = 4'h4,
        EAU_OP_BYTE_ALU    = 4'h5,
        EAU_OP_ALU_IMM     = 4'h6,
        EAU_OP_BIT         = 4'h7,
        EAU_OP_BIT_REGNUM  = 4'h8,
        EAU_OP_JUMP        = 4'h9,
        EAU_OP_BRANCH      = 4'hA,
        EAU_OP_STACK       = 4'hB,
        EAU_OP_FETCH       = 4'hC
    } eau_op_t;

    // unit states
    typedef enum logic [1:0] {
        EAU_S_IDLE = 2'b00,
        EAU_S_WAIT = 2'b01,
        EAU_S_DONE = 2'b10
    } eau_state_t;

    // request from the instruction decoder
    typedef struct packed {
        eau_mode_t  mode;
        eau_op_t    op;
        logic [2:0] reg_sel;
        logic       reg_high;
        logic [7:0] byte2;
        logic [15:0] word34;
        logic [2:0] bitnum4;
        logic       bitnum_in_b4;
        logic       small_two;
        logic [15:0] pc_next;
        logic [7:0] condition_code_byte;
    } eau_req_t;

    // result toward the datapath
    typedef struct packed {
        logic [15:0] addr;
        logic        mem_access;
        logic        word;
        logic        is_write;
        logic [15:0] operand;
        logic [2:0]  bitnum;
        logic        wb_en;
        logic [2:0]  wb_sel;
        logic [15:0] wb_val;
        logic        illegal;
    } eau_res_t;
endpackage

// file: dv/eau_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// register file and page-zero word partner
// ****************************************
module eau_mem_model (
    // clock
    input  wire logic             clk,
    // general register file
    input  wire logic [7:0][15:0] gr_file,
    input  wire logic [2:0]       gr_rd_sel,
    output logic [15:0]           gr_rd_data,
    // vector and stack word port
    input  wire logic             vec_rd,
    input  wire logic [15:0]      vec_addr,
    input  wire logic             ack_force,
    input  wire logic [1:0]       ack_delay,
    input  wire logic [15:0]      pop_word,
    output logic                  vec_ack,
    output logic [15:0]           vec_data
);
    logic [1:0] wait_cnt;  // cycles waited on the current read

    // register read is combinational; index 7 is the stack pointer
    assign gr_rd_data = gr_file[gr_rd_sel];

    initial begin
        vec_ack = 1'b0;
        vec_data = 16'h5A5A;
        wait_cnt = 2'h0;
    end

    // answer after a variable delay; data is junk outside the ack cycle
    always @(posedge clk) begin
        if ((vec_rd || ack_force) && wait_cnt == ack_delay) begin
            vec_ack <= 1'b1;
            wait_cnt <= 2'h0;
            // stack words are always whole words
            vec_data <= ack_force ? pop_word
                                  : {~vec_addr[7:0], vec_addr[7:0]};
        end else begin
            vec_ack <= 1'b0;
            wait_cnt <= (vec_rd || ack_force) ? wait_cnt + 2'h1 : 2'h0;
            vec_data <= ~vec_data;
        end
    end
endmodule // eau_mem_model

// file: dv/tb_effective_address_unit.sv
`timescale 1ns/1ps
module tb_effective_address_unit;
    import eau_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic             clk, rst_b, req_valid, ack_force;
    eau_req_t         req;
    eau_res_t         res;
    logic [2:0]       gr_rd_sel;
    logic [15:0]      gr_rd_data, vec_addr, vec_data, ccr_word, pop_word;
    logic             vec_rd, vec_ack, res_valid;
    logic [7:0]       ccr_popped;
    logic [7:0][15:0] gr_file;
    logic [1:0]       ack_delay;
    logic [9:0]       tbl [31];  // mode, op, illegal, stack pointer
    int               fails, samples_checked;

    eau_unit i_eau_unit (
        .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .gr_rd_sel(gr_rd_sel), .gr_rd_data(gr_rd_data), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_ack(vec_ack), .vec_data(vec_data),
        .res_valid(res_valid), .res(res), .ccr_word(ccr_word),
        .ccr_popped(ccr_popped));

    eau_mem_model i_eau_mem_model (
        .clk(clk), .gr_file(gr_file), .gr_rd_sel(gr_rd_sel),
        .gr_rd_data(gr_rd_data), .vec_rd(vec_rd), .vec_addr(vec_addr),
        .ack_force(ack_force), .ack_delay(ack_delay),
        .pop_word(pop_word), .vec_ack(vec_ack), .vec_data(vec_data));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one request, then the model's expectation against the result
    task automatic do_op(input eau_mode_t m, input eau_op_t o,
                         input logic bad, input logic sp);
        eau_req_t    r;
        logic [63:0] rnd;
        logic [15:0] g, ea, va, step;
        logic        wd, dm, am;
        int          n;
        rnd = {$urandom, $urandom};
        {r.reg_high, r.byte2, r.word34, r.bitnum4, r.bitnum_in_b4,
         r.small_two, r.pc_next, r.condition_code_byte} = rnd[53:0];
        r.mode = m;
        r.op = o;
        r.reg_sel = sp ? 3'h7 : 3'($urandom % 7);
        wd = !(o inside {EAU_OP_BYTE_MOVE, EAU_OP_BIT, EAU_OP_BYTE_ALU});
        dm = o inside {EAU_OP_BYTE_MOVE, EAU_OP_WORD_MOVE, EAU_OP_BIT};
        step = wd ? 16'h0002 : 16'h0001;
        va = 16'hFFFF;
        am = 1'b1;
        @(posedge clk);
        // register file settled after the caller's update
        g = gr_file[r.reg_sel];
        ea = g;
        req_valid <= 1'b1;
        req <= r;
        ack_delay <= 2'($urandom);
        pop_word <= 16'($urandom);
        ack_force <= (m == EAU_M_CCR_POP);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (n < 20) begin
            @(posedge clk);
            #1;
            if (vec_rd === 1'b1) va = vec_addr;
            if (res_valid === 1'b1) break;
            n++;
        end
        ack_force <= 1'b0;
        if (n == 20) begin
            fails++;
            $display("Error res_valid expected 1 seen 0");
            print_verdict();
        end
        if (!(m inside {EAU_M_MEM_IND, EAU_M_CCR_POP})) begin
            check("latency", 16'(n), 16'h0000);
        end
        check("illegal", res.illegal, bad);
        check("bitnum", res.bitnum, r.bitnum_in_b4 ? r.bitnum4
                                                 : r.byte2[2:0]);
        check("is_write", res.is_write,
              m inside {EAU_M_PRE_DEC, EAU_M_CCR_PUSH});
        if (bad) begin
            check("mem_access", res.mem_access, 1'b0);
            check("wb_en", res.wb_en, 1'b0);
        end else begin
            case (m)
                EAU_M_REG_DIRECT: begin
                    am = 1'b0;
                    if (wd) check("operand", res.operand, g);
                    else check("operand", res.operand[7:0],
                               r.reg_high ? g[15:8] : g[7:0]);
                end
                EAU_M_DISP: ea = g + r.word34;
                EAU_M_POST_INC: begin
                    check("wb_val", res.wb_val, g + step);
                end
                EAU_M_PRE_DEC: begin
                    ea = g - step;
                    check("wb_val", res.wb_val, ea);
                end
                EAU_M_ABS_SHORT: ea = {8'hFF, r.byte2};
                EAU_M_ABS_LONG: ea = r.word34;
                EAU_M_IMM8: begin
                    am = 1'b0;
                    check("imm8", res.operand, (o == EAU_OP_SMALL_CONST) ?
                          (r.small_two ? 16'h0002 : 16'h0001) :
                          {8'h00, r.byte2});
                end
                EAU_M_IMM16: begin
                    am = 1'b0;
                    check("imm16", res.operand, r.word34);
                end
                EAU_M_PC_REL: begin
                    ea = r.pc_next + {{8{r.byte2[7]}}, r.byte2};
                end
                EAU_M_MEM_IND: begin
                    ea = {~r.byte2, r.byte2};
                    check("vec_addr", va, {8'h00, r.byte2});
                end
                EAU_M_CCR_PUSH: begin
                    am = 1'b0;
                    check("ccr_word", ccr_word, {r.condition_code_byte, r.condition_code_byte});
                end
                EAU_M_CCR_POP: begin
                    am = 1'b0;
                    check("ccr_pop", ccr_popped, pop_word[15:8]);
                end
                EAU_M_FETCH: ea = r.pc_next;
                default: ea = g;
            endcase
            if (m inside {EAU_M_POST_INC, EAU_M_PRE_DEC}) begin
                check("wb_en", res.wb_en, 1'b1);
                check("wb_sel", res.wb_sel, r.reg_sel);
            end
            if (am && dm) begin
                check("mem_access", res.mem_access, 1'b1);
                check("word", res.word, wd);
            end
            if (am) begin
                check("addr", res.addr, wd ? ea & 16'hFFFE : ea);
            end
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fails = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        ack_force = 1'b0;
        pop_word = 16'h0000;
        gr_file = '0;
        ack_delay = 2'h0;
        void'($urandom(32'hC387EC3E));
        tbl = '{
            {EAU_M_REG_DIRECT, EAU_OP_BYTE_ALU, 2'b00},
            {EAU_M_REG_DIRECT, EAU_OP_WORD_ARITH, 2'b00},
            {EAU_M_REG_IND, EAU_OP_BYTE_MOVE, 2'b00},
            {EAU_M_REG_IND, EAU_OP_WORD_MOVE, 2'b00},
            {EAU_M_DISP, EAU_OP_WORD_MOVE, 2'b00},
            {EAU_M_POST_INC, EAU_OP_BYTE_MOVE, 2'b00},
            {EAU_M_POST_INC, EAU_OP_WORD_MOVE, 2'b00},
            {EAU_M_POST_INC, EAU_OP_WORD_MOVE, 2'b01},
            {EAU_M_PRE_DEC, EAU_OP_BYTE_MOVE, 2'b00},
            {EAU_M_PRE_DEC, EAU_OP_WORD_MOVE, 2'b01},
            {EAU_M_ABS_SHORT, EAU_OP_BIT, 2'b00},
            {EAU_M_ABS_SHORT, EAU_OP_BYTE_MOVE, 2'b00},
            {EAU_M_ABS_LONG, EAU_OP_JUMP, 2'b00},
            {EAU_M_ABS_LONG, EAU_OP_WORD_MOVE, 2'b00},
            {EAU_M_IMM8, EAU_OP_ALU_IMM, 2'b00},
            {EAU_M_IMM16, EAU_OP_WORD_MOVE, 2'b00},
            {EAU_M_PC_REL, EAU_OP_BRANCH, 2'b00},
            {EAU_M_MEM_IND, EAU_OP_JUMP, 2'b00},
            {EAU_M_CCR_PUSH, EAU_OP_STACK, 2'b01},
            {EAU_M_CCR_POP, EAU_OP_STACK, 2'b01},
            {EAU_M_FETCH, EAU_OP_FETCH, 2'b00},
            {EAU_M_DISP, EAU_OP_BYTE_ALU, 2'b10},
            {EAU_M_PC_REL, EAU_OP_BYTE_MOVE, 2'b10},
            {EAU_M_MEM_IND, EAU_OP_WORD_MOVE, 2'b10},
            {EAU_M_IMM16, EAU_OP_BYTE_MOVE, 2'b10},
            {EAU_M_ABS_SHORT, EAU_OP_WORD_MOVE, 2'b10},
            {EAU_M_ABS_LONG, EAU_OP_BIT, 2'b10},
            {EAU_M_REG_IND, EAU_OP_BYTE_ALU, 2'b10},
            {EAU_M_REG_DIRECT, EAU_OP_JUMP, 2'b10},
            {EAU_M_POST_INC, EAU_OP_BYTE_MOVE, 2'b11},
            {EAU_M_IMM8, EAU_OP_SMALL_CONST, 2'b00}};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check("res_valid", res_valid, 1'b0);
        // each table entry three times with fresh registers
        for (int k = 0; k < 93; k++) begin
            @(posedge clk);
            for (int i = 0; i < 8; i++) gr_file[i] <= 16'($urandom);
            do_op(eau_mode_t'(tbl[k % 31][9:6]),
                  eau_op_t'(tbl[k % 31][5:2]),
                  tbl[k % 31][1], tbl[k % 31][0]);
        end
        print_verdict();
    end
endmodule // tb_effective_address_unit
